// ### rtl/asmci_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module asmci_sync3 (
    input wire logic clk, // Bit clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic async_in, // Pin level from outside the clock domain
    output logic level_out // Settled level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } asmci_sync_t;

    asmci_sync_t st_ff;
    asmci_sync_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // A change counts only once two settled stages agree
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.lvl = st_ff.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.lvl;

endmodule
`default_nettype wire

// ### rtl/asmci_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - Period marker mode emits one pulse per pattern period for PRBS, zero and data.
// RL2 - Single channel position: 1 to lcm(len,64)-79, 16-bit steps, capped.
// RL3 - Two channels position: 1 to lcm(len,128)-160, 32-bit steps, capped.
// RL4 - Four channels position: 1 to lcm(len,256)-319, 64-bit steps, capped.
// RL5 - Alternate pattern: marker only in the selected A or B period.
// RL6 - Mixed data: marker over whole block pattern, placed by block and row.
// RL7 - Mixed alternate: marker only for selected block, A/B choice and row.
// RL8 - Sequence: marker only in selected block, single-channel position range; the code applies the range of the set GANG.
// RL9 - Host repeats short patterns to at least 129, 257 or 513 bits.
// RL10 - Burst mode can copy the gated-window marker onto the aux output.
// RL11 - Window marker rises after programmed delay, stays high programmed width.
// RL12 - Delay and width range 0 to cycle minus margin, in gang-scaled steps.
// RL13 - External fault insert uses aux input as edge or level timing.
// RL14 - Ganged: only first slot input inserts errors, with 4-bit grain.
// RL15 - A/B swap mode switches patterns from the aux input level.
// RL16 - Step mode takes sequence transitions from aux input edges.
// RL17 - External burst gate comes from aux input; ganged uses first slot only.
// RL18 - Gate edge starts burst on rising edge; gate level enables while high.
// RL19 - Chassis alignment takes the shared timing signal from aux input.
// RL20 - Aux input serves one function; aux output drives one marker type.
// RL21 - Position counter restarts each period, fixed-width pulse on match.
module asmci_top #(
    parameter int POS_W = 39,
    parameter int CYC_W = 34,
    parameter int BLK_W = 8,
    parameter int ROW_W = 8
) (
    input wire logic CLOCK, // Pattern bit clock
    input wire logic RST_N, // Synchronous reset, active low
    input wire asmci_pkg::asmci_gang_t GANG, // Ganged channel count
    input wire logic SLOT_FIRST, // This module sits in the first slot
    input wire asmci_pkg::asmci_out_sel_t OUT_SEL, // Aux output marker type
    input wire asmci_pkg::asmci_pat_t PAT_KIND, // Test pattern kind
    input wire logic [POS_W-1:0] PERIOD_LEN, // Period, lcm of length and grain
    input wire logic [POS_W-1:0] MARK_POS, // Marker bit position
    input wire logic MARK_SEL_B, // Marker in pattern B when high
    input wire logic [BLK_W-1:0] MARK_BLOCK, // Marker block number
    input wire logic [ROW_W-1:0] MARK_ROW, // Marker row number
    input wire logic PAT_START, // First bit of a pattern period
    input wire logic PAT_IS_B, // Pattern B is being sent
    input wire logic [BLK_W-1:0] CUR_BLOCK, // Current block number
    input wire logic [ROW_W-1:0] CUR_ROW, // Current row number
    input wire logic ROW_START, // First bit of a row
    input wire logic [CYC_W-1:0] BURST_CYCLE, // Burst cycle in bits
    input wire logic [CYC_W-1:0] WIN_DELAY, // Window marker delay in bits
    input wire logic [CYC_W-1:0] WIN_WIDTH, // Window marker width in bits
    input wire logic BURST_ON, // Burst sequencing active
    input wire logic BURST_START, // First bit of burst data
    input wire asmci_pkg::asmci_in_sel_t IN_SEL, // Aux input function
    input wire asmci_pkg::asmci_src_t ERR_SRC, // Error timing source
    input wire asmci_pkg::asmci_src_t BURST_SRC, // Burst gate source
    input wire logic SEQ_EXT_TRIG, // Sequence steps on external trigger
    input wire logic AUX_IN, // Aux input pin
    output logic AUX_OUT, // Aux output pin
    output logic ERR_INSERT, // Insert error now
    output logic AB_SELECT_B, // Send pattern B
    output logic SEQ_STEP, // Advance sequence state
    output logic BURST_GATE_START, // Start burst
    output logic BURST_GATE_EN, // Burst data allowed
    output logic CHASSIS_SYNC, // Chassis alignment pulse
    output logic CFG_ERR // Marker settings out of range
);

    if (POS_W < asmci_pkg::POS_W_MIN || CYC_W < asmci_pkg::CYC_W_MIN) begin : g_chk
        $error("asmci_top: counter widths too narrow");
    end

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [6:0] step_of(asmci_pkg::asmci_gang_t g);
        unique case (g)
            asmci_pkg::GANG_2: step_of = asmci_pkg::STEP_2;
            asmci_pkg::GANG_4: step_of = asmci_pkg::STEP_4;
            default: step_of = asmci_pkg::STEP_1;
        endcase
    endfunction

    function automatic logic [8:0] pos_margin_of(asmci_pkg::asmci_gang_t g);
        unique case (g)
            asmci_pkg::GANG_2: pos_margin_of = asmci_pkg::POS_MARGIN_2;
            asmci_pkg::GANG_4: pos_margin_of = asmci_pkg::POS_MARGIN_4;
            default: pos_margin_of = asmci_pkg::POS_MARGIN_1;
        endcase
    endfunction

    function automatic logic [38:0] cap_of(asmci_pkg::asmci_gang_t g);
        unique case (g)
            asmci_pkg::GANG_2: cap_of = asmci_pkg::POS_CAP_2;
            asmci_pkg::GANG_4: cap_of = asmci_pkg::POS_CAP_4;
            default: cap_of = asmci_pkg::POS_CAP_1;
        endcase
    endfunction

    function automatic logic [9:0] min_len_of(asmci_pkg::asmci_gang_t g);
        unique case (g)
            asmci_pkg::GANG_2: min_len_of = asmci_pkg::MIN_LEN_2;
            asmci_pkg::GANG_4: min_len_of = asmci_pkg::MIN_LEN_4;
            default: min_len_of = asmci_pkg::MIN_LEN_1;
        endcase
    endfunction

    function automatic logic [8:0] win_margin_of(asmci_pkg::asmci_gang_t g);
        unique case (g)
            asmci_pkg::GANG_2: win_margin_of = asmci_pkg::WIN_MARGIN_2;
            asmci_pkg::GANG_4: win_margin_of = asmci_pkg::WIN_MARGIN_4;
            default: win_margin_of = asmci_pkg::WIN_MARGIN_1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [POS_W-1:0] pos_cnt;
        logic [6:0] mark_cnt;
        logic [CYC_W-1:0] win_cnt;
        logic win_run;
        logic [1:0] grain;
        logic err_pend;
        logic in_prev;
        logic aux_out;
        logic err_out;
        logic ab_out;
        logic seq_out;
        logic bst_start;
        logic bst_en;
        logic chs_out;
        logic cfg_err;
    } asmci_state_t;

    asmci_state_t st_ff;
    asmci_state_t nxt_st;
    logic aux_lvl;

    asmci_sync3 u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .async_in(AUX_IN),
        .level_out(aux_lvl)
    );

    logic [6:0] step;
    logic [POS_W-1:0] step_w;
    logic [POS_W-1:0] pos_limit;
    logic pos_ok;
    logic [CYC_W-1:0] win_limit;
    logic [CYC_W-1:0] win_mask;
    logic win_ok;
    logic first_slot_ok;
    logic in_rise;
    logic hit;
    logic win_on;

    always_comb begin
        step = step_of(GANG);
        step_w = POS_W'(step);
        win_mask = CYC_W'(step) - CYC_W'(1);
        // Period must be long enough and hold the tail margin
        pos_limit = PERIOD_LEN - POS_W'(pos_margin_of(GANG));
        pos_ok = (PERIOD_LEN >= POS_W'(min_len_of(GANG))) // RL9
            && (MARK_POS != '0)
            && (MARK_POS <= pos_limit) // RL2 RL3 RL4
            && (MARK_POS <= POS_W'(cap_of(GANG)))
            && (((MARK_POS - POS_W'(1)) & (step_w - POS_W'(1))) == '0);
        win_limit = BURST_CYCLE - CYC_W'(win_margin_of(GANG));
        win_ok = (BURST_CYCLE >= CYC_W'(win_margin_of(GANG)))
            && (WIN_DELAY <= win_limit) && (WIN_WIDTH <= win_limit) // RL12
            && ((WIN_DELAY & win_mask) == '0) && ((WIN_WIDTH & win_mask) == '0);
        // Ganged error insert and burst gate only listen on the first slot
        first_slot_ok = (GANG == asmci_pkg::GANG_1) || SLOT_FIRST; // RL14 RL17
        in_rise = aux_lvl && !st_ff.in_prev;
        win_on = st_ff.win_run && (st_ff.win_cnt >= WIN_DELAY)
            && ((st_ff.win_cnt - WIN_DELAY) < WIN_WIDTH); // RL11
    end

    // Marker match: counter is 1 on the bit after PAT_START
    always_comb begin
        hit = 1'b0;
        unique case (PAT_KIND)
            asmci_pkg::PAT_PRBS, asmci_pkg::PAT_ZERO, asmci_pkg::PAT_DATA: begin
                hit = pos_ok && (st_ff.pos_cnt == MARK_POS); // RL1
            end
            asmci_pkg::PAT_ALT: begin
                hit = pos_ok && (st_ff.pos_cnt == MARK_POS) && (PAT_IS_B == MARK_SEL_B); // RL5
            end
            asmci_pkg::PAT_MIX_DATA: begin
                hit = ROW_START && (CUR_BLOCK == MARK_BLOCK) && (CUR_ROW == MARK_ROW); // RL6
            end
            asmci_pkg::PAT_MIX_ALT: begin
                hit = ROW_START && (CUR_BLOCK == MARK_BLOCK) && (CUR_ROW == MARK_ROW)
                    && (PAT_IS_B == MARK_SEL_B); // RL7
            end
            asmci_pkg::PAT_SEQ: begin
                hit = pos_ok && (st_ff.pos_cnt == MARK_POS) && (CUR_BLOCK == MARK_BLOCK); // RL8
            end
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_st = st_ff;
        nxt_st.in_prev = aux_lvl;
        nxt_st.grain = st_ff.grain + 2'h1;

        // Position counter restarts at each period start
        if (PAT_START) begin
            nxt_st.pos_cnt = POS_W'(1); // RL21
        end else begin
            nxt_st.pos_cnt = st_ff.pos_cnt + POS_W'(1);
        end
        // A new match restarts the fixed-width marker pulse
        if (OUT_SEL == asmci_pkg::OUT_PERIOD && hit) begin
            nxt_st.mark_cnt = step; // RL21
        end else if (st_ff.mark_cnt != '0) begin
            nxt_st.mark_cnt = st_ff.mark_cnt - 7'h01;
        end

        // Window counter runs one burst cycle from burst start
        if (BURST_ON && BURST_START) begin
            nxt_st.win_run = 1'b1;
            nxt_st.win_cnt = '0;
        end else if (st_ff.win_run) begin
            nxt_st.win_cnt = st_ff.win_cnt + CYC_W'(1);
            if (!BURST_ON || st_ff.win_cnt >= BURST_CYCLE - CYC_W'(1)) begin
                nxt_st.win_run = 1'b0;
            end
        end

        // At most one marker type reaches the pin; none with OUT_OFF
        unique case (OUT_SEL)
            asmci_pkg::OUT_PERIOD: nxt_st.aux_out = (nxt_st.mark_cnt != '0); // RL20
            asmci_pkg::OUT_WINDOW: nxt_st.aux_out = BURST_ON && win_ok && win_on; // RL10
            default: nxt_st.aux_out = 1'b0;
        endcase
        nxt_st.cfg_err = ((OUT_SEL == asmci_pkg::OUT_PERIOD) && !pos_ok
            && (PAT_KIND != asmci_pkg::PAT_MIX_DATA) && (PAT_KIND != asmci_pkg::PAT_MIX_ALT))
            || ((OUT_SEL == asmci_pkg::OUT_WINDOW) && !win_ok);

        // Input side: every function output idles unless selected
        nxt_st.seq_out = 1'b0;
        nxt_st.bst_start = 1'b0;
        nxt_st.chs_out = 1'b0;
        nxt_st.bst_en = 1'b0;
        nxt_st.ab_out = 1'b0;
        nxt_st.err_out = 1'b0;
        nxt_st.err_pend = 1'b0;
        unique case (IN_SEL)
            asmci_pkg::IN_ERR: begin
                if (!first_slot_ok || ERR_SRC == asmci_pkg::SRC_OFF) begin
                    nxt_st.err_out = 1'b0;
                end else if (GANG == asmci_pkg::GANG_1) begin
                    nxt_st.err_out = (ERR_SRC == asmci_pkg::SRC_EDGE) ? in_rise : aux_lvl; // RL13
                end else begin
                    // Ganged: output changes only on 4-bit boundaries
                    nxt_st.err_pend = st_ff.err_pend || in_rise;
                    nxt_st.err_out = st_ff.err_out;
                    if (st_ff.grain == asmci_pkg::ERR_GRAIN_LAST) begin
                        nxt_st.err_out = (ERR_SRC == asmci_pkg::SRC_EDGE)
                            ? (st_ff.err_pend || in_rise) : aux_lvl; // RL14
                        nxt_st.err_pend = 1'b0;
                    end
                end
            end
            asmci_pkg::IN_AB: begin
                nxt_st.ab_out = aux_lvl && ((PAT_KIND == asmci_pkg::PAT_ALT)
                    || (PAT_KIND == asmci_pkg::PAT_MIX_ALT)); // RL15
            end
            asmci_pkg::IN_SEQ: begin
                nxt_st.seq_out = in_rise && SEQ_EXT_TRIG && (PAT_KIND == asmci_pkg::PAT_SEQ); // RL16
            end
            asmci_pkg::IN_BURST: begin
                if (first_slot_ok) begin
                    nxt_st.bst_start = in_rise && (BURST_SRC == asmci_pkg::SRC_EDGE); // RL18
                    nxt_st.bst_en = aux_lvl && (BURST_SRC == asmci_pkg::SRC_LEVEL); // RL18
                end
            end
            asmci_pkg::IN_CHASSIS: nxt_st.chs_out = in_rise; // RL19
            default: nxt_st.chs_out = 1'b0; // RL20
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign AUX_OUT = st_ff.aux_out;
    assign ERR_INSERT = st_ff.err_out;
    assign AB_SELECT_B = st_ff.ab_out;
    assign SEQ_STEP = st_ff.seq_out;
    assign BURST_GATE_START = st_ff.bst_start;
    assign BURST_GATE_EN = st_ff.bst_en;
    assign CHASSIS_SYNC = st_ff.chs_out;
    assign CFG_ERR = st_ff.cfg_err;

    ////////////////////////////////////////////////////////////////////////////

    AST_PERIOD_RESTART: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL21
        PAT_START |=> st_ff.pos_cnt == POS_W'(1))
        else $error("Position counter did not restart at period start");

    AST_MARK_WIDTH: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL1
        (OUT_SEL == asmci_pkg::OUT_PERIOD && hit && GANG == asmci_pkg::GANG_1
            && $stable(OUT_SEL))
        |=> ##1 AUX_OUT [*8])
        else $error("Period marker shorter than its fixed width");

    AST_MARK_BAD_POS: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL2
        (PAT_KIND == asmci_pkg::PAT_PRBS && MARK_POS == '0) |-> !hit)
        else $error("Marker matched an illegal position");

    AST_ALT_SIDE: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL5
        (PAT_KIND == asmci_pkg::PAT_ALT && PAT_IS_B != MARK_SEL_B) |-> !hit)
        else $error("Marker fired in the unselected pattern");

    AST_SEQ_BLOCK: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL8
        (PAT_KIND == asmci_pkg::PAT_SEQ && CUR_BLOCK != MARK_BLOCK) |-> !hit)
        else $error("Sequence marker fired outside selected block");

    AST_WIN_DELAY: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL11
        (OUT_SEL == asmci_pkg::OUT_WINDOW && st_ff.win_run && st_ff.win_cnt < WIN_DELAY)
        |=> !AUX_OUT)
        else $error("Window marker rose before its delay");

    AST_ONE_FUNC: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL20
        $onehot0({ERR_INSERT, AB_SELECT_B, SEQ_STEP, BURST_GATE_START,
            BURST_GATE_EN, CHASSIS_SYNC}))
        else $error("Aux input drove more than one function");

    AST_SLOT_ONLY: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL14
        (GANG != asmci_pkg::GANG_1 && !SLOT_FIRST && $stable(SLOT_FIRST)
            && $stable(GANG)) |=> !ERR_INSERT && !BURST_GATE_START && !BURST_GATE_EN)
        else $error("Non-first slot used the aux input");

    AST_SEQ_PULSE: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL16
        SEQ_STEP |=> !SEQ_STEP)
        else $error("Sequence step longer than one cycle");

    AST_CHS_EDGE: assert property (@(posedge CLOCK) disable iff (!RST_N) // RL19
        (IN_SEL == asmci_pkg::IN_CHASSIS && aux_lvl && !st_ff.in_prev) |=> CHASSIS_SYNC)
        else $error("Chassis alignment edge lost");

endmodule
`default_nettype wire

// ### shared/asmci_pkg.sv
package asmci_pkg;

    // Widths of the position and burst counters
    localparam int POS_W_MIN = 39;
    localparam int CYC_W_MIN = 34;

    // Largest marker position per gang size
    localparam logic [38:0] POS_CAP_1 = 39'd68719476657;
    localparam logic [38:0] POS_CAP_2 = 39'd137438953312;
    localparam logic [38:0] POS_CAP_4 = 39'd274877906625;

    // Tail margin subtracted from the pattern period per gang size
    localparam logic [8:0] POS_MARGIN_1 = 9'd79;
    localparam logic [8:0] POS_MARGIN_2 = 9'd160;
    localparam logic [8:0] POS_MARGIN_4 = 9'd319;

    // Shortest pattern period the host may program per gang size
    localparam logic [9:0] MIN_LEN_1 = 10'd129;
    localparam logic [9:0] MIN_LEN_2 = 10'd257;
    localparam logic [9:0] MIN_LEN_4 = 10'd513;

    // Position and window step, marker pulse width, window margin
    localparam logic [6:0] STEP_1 = 7'd16;
    localparam logic [6:0] STEP_2 = 7'd32;
    localparam logic [6:0] STEP_4 = 7'd64;
    localparam logic [8:0] WIN_MARGIN_1 = 9'd64;
    localparam logic [8:0] WIN_MARGIN_2 = 9'd128;
    localparam logic [8:0] WIN_MARGIN_4 = 9'd256;

    // Error timing grain in ganged operation
    localparam logic [1:0] ERR_GRAIN_LAST = 2'h3;

    typedef enum logic [2:0] {
        GANG_1 = 3'h1,
        GANG_2 = 3'h2,
        GANG_4 = 3'h4
    } asmci_gang_t;

    typedef enum logic [2:0] {
        OUT_OFF = 3'h1,
        OUT_PERIOD = 3'h2,
        OUT_WINDOW = 3'h4
    } asmci_out_sel_t;

    typedef enum logic [6:0] {
        PAT_PRBS = 7'h01,
        PAT_ZERO = 7'h02,
        PAT_DATA = 7'h04,
        PAT_ALT = 7'h08,
        PAT_MIX_DATA = 7'h10,
        PAT_MIX_ALT = 7'h20,
        PAT_SEQ = 7'h40
    } asmci_pat_t;

    typedef enum logic [5:0] {
        IN_OFF = 6'h01,
        IN_ERR = 6'h02,
        IN_AB = 6'h04,
        IN_SEQ = 6'h08,
        IN_BURST = 6'h10,
        IN_CHASSIS = 6'h20
    } asmci_in_sel_t;

    typedef enum logic [2:0] {
        SRC_OFF = 3'h1,
        SRC_EDGE = 3'h2,
        SRC_LEVEL = 3'h4
    } asmci_src_t;

endpackage

// ### test/asmci_partner.sv
`timescale 1ns/1ps
`default_nettype none
module asmci_partner (
    input wire logic clk, // Bit clock of the generator
    input wire logic fire, // Request one timing pulse
    input wire logic [3:0] hi_len, // Pulse length in bit clocks
    output logic aux // Timing signal into the first slot's aux input
);
    logic [3:0] left;
    initial begin
        left = 4'h0;
        aux = 1'b0;
    end
    always @(posedge clk) begin
        if (fire) begin
            left <= hi_len;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    // Outside equipment runs on its own timing: the pin moves mid-cycle, low when idle
    always @(left) aux <= #7 (left != 4'h0);
endmodule
`default_nettype wire

// ### test/test_aux_sync_marker_and_control_input.sv
`timescale 1ns/1ps
`default_nettype none
module test_aux_sync_marker_and_control_input;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    asmci_pkg::asmci_gang_t GANG = asmci_pkg::GANG_1;
    logic SLOT_FIRST = 1'b1;
    asmci_pkg::asmci_out_sel_t OUT_SEL = asmci_pkg::OUT_PERIOD;
    asmci_pkg::asmci_pat_t PAT_KIND = asmci_pkg::PAT_PRBS;
    logic [38:0] PERIOD_LEN = 39'h400;
    logic [38:0] MARK_POS = 39'h1;
    logic MARK_SEL_B = 1'b0, PAT_START = 1'b0, PAT_IS_B = 1'b0, ROW_START = 1'b0;
    logic [7:0] MARK_BLOCK = 8'h05, MARK_ROW = 8'h00, CUR_BLOCK = 8'h05, CUR_ROW = 8'h00;
    logic [33:0] BURST_CYCLE = 34'h500, WIN_DELAY = 34'h0, WIN_WIDTH = 34'h10;
    logic BURST_ON = 1'b0, BURST_START = 1'b0, SEQ_EXT_TRIG = 1'b0, fire = 1'b0;
    asmci_pkg::asmci_in_sel_t IN_SEL = asmci_pkg::IN_OFF;
    asmci_pkg::asmci_src_t ERR_SRC = asmci_pkg::SRC_OFF, BURST_SRC = asmci_pkg::SRC_OFF;
    logic [3:0] hi_len = 4'h6;
    logic AUX_IN, AUX_OUT, ERR_INSERT, AB_SELECT_B, SEQ_STEP;
    logic BURST_GATE_START, BURST_GATE_EN, CHASSIS_SYNC, CFG_ERR;
    int fails = 0, n_compared = 0, cyc = 0, seed = 32'hee0b, pos, step;
    always #20 CLOCK = ~CLOCK;

    asmci_top u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .GANG(GANG), .SLOT_FIRST(SLOT_FIRST),
        .OUT_SEL(OUT_SEL), .PAT_KIND(PAT_KIND), .PERIOD_LEN(PERIOD_LEN), .MARK_POS(MARK_POS),
        .MARK_SEL_B(MARK_SEL_B), .MARK_BLOCK(MARK_BLOCK), .MARK_ROW(MARK_ROW),
        .PAT_START(PAT_START), .PAT_IS_B(PAT_IS_B), .CUR_BLOCK(CUR_BLOCK), .CUR_ROW(CUR_ROW),
        .ROW_START(ROW_START), .BURST_CYCLE(BURST_CYCLE), .WIN_DELAY(WIN_DELAY),
        .WIN_WIDTH(WIN_WIDTH), .BURST_ON(BURST_ON), .BURST_START(BURST_START),
        .IN_SEL(IN_SEL), .ERR_SRC(ERR_SRC), .BURST_SRC(BURST_SRC), .SEQ_EXT_TRIG(SEQ_EXT_TRIG),
        .AUX_IN(AUX_IN), .AUX_OUT(AUX_OUT), .ERR_INSERT(ERR_INSERT), .AB_SELECT_B(AB_SELECT_B),
        .SEQ_STEP(SEQ_STEP), .BURST_GATE_START(BURST_GATE_START),
        .BURST_GATE_EN(BURST_GATE_EN), .CHASSIS_SYNC(CHASSIS_SYNC), .CFG_ERR(CFG_ERR));
    asmci_partner u_far (.clk(CLOCK), .fire(fire), .hi_len(hi_len), .aux(AUX_IN));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Start strobe, then watch 600 cycles; first_exp -1 means no marker at all
    task automatic meas(input logic burst, input int first_exp, input int w_exp, input string what);
        int first;
        int hi;
        first = -1;
        hi = 0;
        // Long enough for the marker that follows reset release to die out
        repeat (20) @(posedge CLOCK);
        if (burst) BURST_START <= 1'b1;
        else PAT_START <= 1'b1;
        ROW_START <= !burst;
        @(posedge CLOCK);
        BURST_START <= 1'b0;
        PAT_START <= 1'b0;
        ROW_START <= 1'b0;
        for (int k = 0; k < 600; k++) begin
            @(negedge CLOCK);
            if (AUX_OUT === 1'b1) begin
                hi++;
                if (first < 0) first = k;
            end
        end
        chk({what, " first"}, first_exp, first);
        chk({what, " width"}, w_exp, hi);
        $display("test %s done", what);
    endtask

    // One timing pulse from outside; count high cycles of each steered output
    task automatic aux_case(input asmci_pkg::asmci_in_sel_t sel, input asmci_pkg::asmci_src_t es,
            input asmci_pkg::asmci_src_t bs, input asmci_pkg::asmci_pat_t pk, input logic slot,
            input asmci_pkg::asmci_gang_t g, input int idx, input logic lvl, input string what);
        int cnt[6];
        logic [5:0] o;
        @(posedge CLOCK);
        IN_SEL <= sel; ERR_SRC <= es; BURST_SRC <= bs; PAT_KIND <= pk; SLOT_FIRST <= slot;
        GANG <= g; BURST_ON <= (bs != asmci_pkg::SRC_OFF); SEQ_EXT_TRIG <= 1'b1;
        hi_len <= 4'(3 + $unsigned($random(seed)) % 10);
        cnt = '{default: 0};
        repeat (6) @(posedge CLOCK);
        fire <= 1'b1;
        @(posedge CLOCK);
        fire <= 1'b0;
        for (int k = 0; k < 30; k++) begin
            @(negedge CLOCK);
            o = {CHASSIS_SYNC, BURST_GATE_EN, BURST_GATE_START, SEQ_STEP, AB_SELECT_B, ERR_INSERT};
            for (int i = 0; i < 6; i++) cnt[i] += (o[i] === 1'b1);
        end
        // Ganged error timing holds its pulse for one whole 4-bit grain
        for (int i = 0; i < 6; i++) chk(what, (i != idx) ? 0 : lvl ? int'(hi_len)
            : (g == asmci_pkg::GANG_1) ? 1 : int'(asmci_pkg::ERR_GRAIN_LAST) + 1, cnt[i]);
        $display("test %s done", what);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Cut a hang short; the whole sequence needs under 17000 cycles
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge CLOCK);
        RST_N <= 1'b1; // Period of 1024 is above every minimum length
        for (int g = 0; g < 3; g++) begin
            GANG <= asmci_pkg::asmci_gang_t'(3'h1 << g);
            step = 16 << g;
            for (int p = 0; p < 3; p++) begin
                PAT_KIND <= asmci_pkg::asmci_pat_t'(7'h01 << p);
                pos = (p == 0) ? 1 : 1 + step * ($unsigned($random(seed)) % 8);
                MARK_POS <= 39'(pos);
                meas(1'b0, pos, step, "period marker");
                chk("range flag", 1'b0, CFG_ERR);
            end
            for (int r = 0; r < 2; r++) begin
                MARK_POS <= 39'((r == 0) ? 0 : pos + 1);
                meas(1'b0, -1, 0, "refused position");
                chk("range flag", 1'b1, CFG_ERR);
            end
        end
        GANG <= asmci_pkg::GANG_1;
        MARK_POS <= 39'h21;
        PAT_KIND <= asmci_pkg::PAT_ALT;
        MARK_SEL_B <= 1'b1;
        meas(1'b0, -1, 0, "marker in other pattern");
        PAT_IS_B <= 1'b1;
        meas(1'b0, 33, 16, "marker in chosen pattern");
        PAT_KIND <= asmci_pkg::PAT_SEQ;
        meas(1'b0, 33, 16, "marker in chosen block");
        CUR_BLOCK <= 8'h06;
        meas(1'b0, -1, 0, "marker in other block");
        CUR_BLOCK <= 8'h05;
        for (int m = 0; m < 2; m++) begin
            PAT_KIND <= m ? asmci_pkg::PAT_MIX_ALT : asmci_pkg::PAT_MIX_DATA;
            meas(1'b0, 0, 16, "row marker");
        end
        OUT_SEL <= asmci_pkg::OUT_OFF;
        meas(1'b0, -1, 0, "output off");
        OUT_SEL <= asmci_pkg::OUT_WINDOW;
        BURST_ON <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            GANG <= asmci_pkg::asmci_gang_t'(3'h1 << g);
            step = 16 << g;
            pos = step * ($unsigned($random(seed)) % 4);
            WIN_DELAY <= 34'(pos);
            WIN_WIDTH <= 34'(step * (1 + g));
            meas(1'b1, pos + 1, step * (1 + g), "window marker");
        end
        OUT_SEL <= asmci_pkg::OUT_OFF;
        aux_case(asmci_pkg::IN_ERR, asmci_pkg::SRC_EDGE, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_1, 0, 1'b0, "error edge");
        aux_case(asmci_pkg::IN_ERR, asmci_pkg::SRC_EDGE, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_2, 0, 1'b0, "error ganged");
        aux_case(asmci_pkg::IN_ERR, asmci_pkg::SRC_LEVEL, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_1, 0, 1'b1, "error level");
        aux_case(asmci_pkg::IN_ERR, asmci_pkg::SRC_LEVEL, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_PRBS, 1'b0, asmci_pkg::GANG_2, -1, 1'b1, "error later slot");
        aux_case(asmci_pkg::IN_AB, asmci_pkg::SRC_OFF, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_MIX_ALT, 1'b1, asmci_pkg::GANG_1, 1, 1'b1, "swap");
        aux_case(asmci_pkg::IN_SEQ, asmci_pkg::SRC_OFF, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_SEQ, 1'b1, asmci_pkg::GANG_1, 2, 1'b0, "step");
        aux_case(asmci_pkg::IN_BURST, asmci_pkg::SRC_OFF, asmci_pkg::SRC_EDGE,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_1, 3, 1'b0, "gate edge");
        aux_case(asmci_pkg::IN_BURST, asmci_pkg::SRC_OFF, asmci_pkg::SRC_LEVEL,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_1, 4, 1'b1, "gate level");
        aux_case(asmci_pkg::IN_BURST, asmci_pkg::SRC_OFF, asmci_pkg::SRC_LEVEL,
            asmci_pkg::PAT_PRBS, 1'b0, asmci_pkg::GANG_4, -1, 1'b1, "gate later slot");
        aux_case(asmci_pkg::IN_CHASSIS, asmci_pkg::SRC_OFF, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_1, 5, 1'b0, "chassis");
        aux_case(asmci_pkg::IN_OFF, asmci_pkg::SRC_EDGE, asmci_pkg::SRC_OFF,
            asmci_pkg::PAT_PRBS, 1'b1, asmci_pkg::GANG_1, -1, 1'b0, "input off");
        end_of_test();
    end
endmodule
`default_nettype wire
